// ### sim/can_fault_protect_asserts.sv
// Checker for the CAN fault protection block
`timescale 1ns/1ps
`default_nettype none
module can_fault_protect_asserts
   import can_fault_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_b_i,
   input wire can_mode_t  mode_i,
   input wire fault_vec_t fault_i,
   input wire logic       tx_reenable_i,
   input wire diag_t      diag_clear_i,
   input wire logic       bus_short_mask_i,
   input wire logic       drv_tx_o,
   input wire logic       drv_enable_o,
   input wire logic       split_enable_o,
   input wire diag_t      diag_o,
   input wire logic       irq_bus_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Bit 1 of the mode is set only in normal and receive-only
   split_on_a: assert property (mode_i[1] |=> split_enable_o) else $error("split off");
   split_off_a: assert property (!mode_i[1] |=> !split_enable_o) else $error("split on");
   hot_off_a: assert property (fault_i.over_temp |-> ##3 !drv_enable_o && diag_o.over_temp)
      else $error("hot driver");
   clamp_off_a: assert property (fault_i.rx_clamp |-> ##3 !drv_enable_o && diag_o.rx_clamp)
      else $error("clamp driver");
   short_irq_a: assert property (fault_i.bus_short ##2 !bus_short_mask_i |=> irq_bus_o)
      else $error("no irq");
   irq_mask_a: assert property (bus_short_mask_i |=> !irq_bus_o) else $error("masked irq");
   hot_sticky_a:
      assert property (diag_o.over_temp && !diag_clear_i.over_temp |=> diag_o.over_temp)
      else $error("flag lost");
   tx_idle_a: assert property (!drv_enable_o |-> drv_tx_o) else $error("tx active");
   cover property (fault_i.over_temp);
   cover property (tx_reenable_i && diag_o.rx_clamp);
   cover property (irq_bus_o);
endmodule
bind can_fault_protect can_fault_protect_asserts chk (.*);
`default_nettype wire

// ### sim/can_fault_protect_tb.sv
// Self-checking testbench for the CAN fault protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
   $display("Error %0t got %h exp %h", $time, a, e); end end
module can_fault_protect_tb
   import can_fault_pkg::*;
;
   typedef struct packed {can_mode_t m; logic [1:0] e;} row_t;
   localparam row_t ROWS [4] = '{'{CAN_MODE_OFF, 2'h0}, '{CAN_MODE_WAKE, 2'h0},
      '{CAN_MODE_RX_ONLY, 2'h2}, '{CAN_MODE_NORMAL, 2'h3}};
   logic       core_clk_i = 0, rst_b_i = 0, tx_bit = 1, tx_i, rx_bus_i, reg2_uv_i = 0;
   logic       reg3_uv_i = 0, uv_sel_reg3_i = 0, tx_reenable_i = 0, bus_short_mask_i = 0;
   logic       drv_tx_o, drv_enable_o, rx_o, split_enable_o, irq_bus_o;
   logic       hl_short = 0, echo_mis;
   can_mode_t  mode_i = CAN_MODE_OFF;
   fault_vec_t fault_i = FAULT_RESET;
   diag_t      diag_clear_i = DIAG_RESET, diag_o;
   int         fail_count = 0, tests_run = 0;
   always #25 core_clk_i = ~core_clk_i;
   // A high-low line short holds the bus recessive whatever is sent
   assign rx_bus_i = tx_i | hl_short;
   host_model host (.tx_bit_i(tx_bit), .rx_i(rx_o), .tx_o(tx_i), .mis_o(echo_mis));
   can_fault_protect dut (.*);
   task automatic step(input int n); repeat (n) @(negedge core_clk_i); endtask
   task automatic pulse;
      tx_reenable_i = 1;
      step(1);
      tx_reenable_i = 0;
   endtask
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #20us;
      fail_count++;
      end_of_test();
   end
   initial begin
      step(12);
      `CHK({drv_enable_o, drv_tx_o, split_enable_o, diag_o, irq_bus_o}, 8'h40)
      rst_b_i = 1;
      foreach (ROWS[i]) begin
         mode_i = ROWS[i].m;
         step(2);
         `CHK({split_enable_o, drv_enable_o}, ROWS[i].e)
      end
      fault_i.over_temp = 1;
      step(3);
      `CHK({drv_enable_o, diag_o.over_temp}, 2'h1)
      fault_i.over_temp = 0;
      step(5);
      `CHK(drv_enable_o, 1'b0)
      tx_bit = TX_DOMINANT;
      step(4);
      `CHK(drv_enable_o, 1'b0)
      tx_bit = TX_RECESSIVE;
      step(4);
      `CHK({drv_enable_o, diag_o.over_temp}, 2'h3)
      diag_clear_i.over_temp = 1;
      step(1);
      diag_clear_i = DIAG_RESET;
      step(1);
      `CHK(diag_o.over_temp, 1'b0)
      fault_i.rx_clamp = 1;
      step(3);
      `CHK({drv_enable_o, diag_o.rx_clamp}, 2'h1)
      // Re-enable while the clamp is still seen must be refused
      pulse();
      fault_i.rx_clamp = 0;
      step(4);
      `CHK(drv_enable_o, 1'b0)
      pulse();
      step(3);
      `CHK(drv_enable_o, 1'b1)
      fault_i.bus_short = 1;
      step(3);
      `CHK({irq_bus_o, diag_o.bus_short, drv_enable_o, split_enable_o}, 4'hF)
      bus_short_mask_i = 1;
      step(2);
      `CHK(irq_bus_o, 1'b0)
      fault_i = FAULT_RESET;
      reg2_uv_i = 1;
      step(3);
      `CHK(diag_o.supply_uv, 1'b1)
      mode_i = CAN_MODE_OFF;
      step(2);
      `CHK({split_enable_o, drv_enable_o, rx_o}, 3'h1)
      uv_sel_reg3_i = 1;
      reg2_uv_i = 0;
      diag_clear_i.supply_uv = 1;
      step(1);
      diag_clear_i = DIAG_RESET;
      `CHK(diag_o.supply_uv, 1'b1)
      step(3);
      diag_clear_i.supply_uv = 1;
      step(1);
      diag_clear_i = DIAG_RESET;
      `CHK(diag_o.supply_uv, 1'b0)
      reg3_uv_i = 1;
      step(3);
      `CHK(diag_o.supply_uv, 1'b1)
      mode_i = CAN_MODE_NORMAL;
      step(2);
      hl_short = 1;
      tx_bit = TX_DOMINANT;
      step(3);
      `CHK({drv_tx_o, echo_mis}, 2'h1)
      tx_bit = TX_RECESSIVE;
      hl_short = 0;
      fault_i.rx_clamp = 1;
      step(3);
      rst_b_i = 0;
      fault_i = FAULT_RESET;
      step(3);
      `CHK({drv_enable_o, drv_tx_o, split_enable_o, diag_o, irq_bus_o}, 8'h40)
      rst_b_i = 1;
      step(4);
      `CHK({drv_enable_o, drv_tx_o, diag_o.rx_clamp}, 3'h6)
      end_of_test();
   end
endmodule
`default_nettype wire

// ### sim/host_model.sv
// Host microcontroller model on the transmit and receive pins
`timescale 1ns/1ps
`default_nettype none
module host_model
   import can_fault_pkg::*;
(
   input  wire logic tx_bit_i,
   input  wire logic rx_i,
   output logic      tx_o,
   output logic      mis_o
);
   assign tx_o = tx_bit_i;
   // Line-to-line short shows as echo mismatch; any momentary difference counts
   assign mis_o = tx_o != rx_i;
endmodule
`default_nettype wire

// ### verilog/can_fault_pkg.sv
// Package with modes, fault records and constants for the CAN fault protection block
package can_fault_pkg;

   typedef enum logic [1:0] {
      CAN_MODE_OFF,
      CAN_MODE_WAKE,
      CAN_MODE_NORMAL,
      CAN_MODE_RX_ONLY
   } can_mode_t;

   // Raw fault indications from the analog sensing
   typedef struct packed {
      logic over_temp;
      logic rx_clamp;
      logic bus_short;
      logic supply_uv;
   } fault_vec_t;

   // Latched diagnostic flags readable by the host
   typedef struct packed {
      logic over_temp;
      logic rx_clamp;
      logic bus_short;
      logic supply_uv;
   } diag_t;

   localparam logic       TX_DOMINANT   = 1'b0;
   localparam logic       TX_RECESSIVE  = 1'b1;
   localparam diag_t      DIAG_RESET    = '0;
   localparam fault_vec_t FAULT_RESET   = '0;
   localparam int         SYNC_STAGES   = 2;

endpackage

// ### verilog/can_fault_protect.sv
// CAN transceiver fault protection, transmit gating and split termination control
// Behaviour
// - Overtemperature disables the transmitter driver stage.
// - Recover from overtemperature without leaving CAN mode.
// - After recovery, wait for TX dominant-to-recessive edge.
// - Permanent RX recessive clamp flags, disables transmitter.
// - Clamp-disabled transmitter stays off until host re-enable.
// - Undervoltage taken from regulator monitor, not own.
// - Bus line short sets flag and unmasked interrupt.
// - Bus short never changes transceiver mode.
// - Split output on in normal/receive-only, else off.
// - Every detected failure reported in host diagnostics.
`timescale 1ns/1ps
`default_nettype none
module can_fault_protect
   import can_fault_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_b_i,
   input  wire can_mode_t  mode_i,
   input  wire logic       tx_i,
   input  wire logic       rx_bus_i,
   input  wire fault_vec_t fault_i,
   input  wire logic       reg2_uv_i,
   input  wire logic       reg3_uv_i,
   input  wire logic       uv_sel_reg3_i,
   input  wire logic       tx_reenable_i,
   input  wire diag_t      diag_clear_i,
   input  wire logic       bus_short_mask_i,
   output logic            drv_tx_o,
   output logic            drv_enable_o,
   output logic            rx_o,
   output logic            split_enable_o,
   output diag_t           diag_o,
   output logic            irq_bus_o
);

   localparam int NSYNC = 6;

   logic [NSYNC-1:0] raw_async;
   logic [NSYNC-1:0] raw_sync;
   logic [NSYNC-1:0] sync_reset_val;
   logic             ot_s;
   logic             clamp_s;
   logic             short_s;
   logic             uv_s;
   logic             tx_s;
   logic             rx_s;

   logic             tx_prev_r;
   logic             ot_lock_r;
   logic             clamp_lock_r;
   logic             tx_enable_nxt;
   logic             tx_rise;
   logic             tx_mode;
   logic             ot_block;
   logic             clamp_block;
   logic             ot_flag_r;
   logic             clamp_flag_r;
   logic             short_flag_r;
   logic             uv_flag_r;

   // Receiver and split termination share one mode decode
   function automatic logic rx_path_on(input can_mode_t m);
      return (m == CAN_MODE_NORMAL) || (m == CAN_MODE_RX_ONLY);
   endfunction

   // Sticky flag update; a new event in the clear cycle keeps the flag
   function automatic logic keep_flag(input logic set, input logic cur, input logic clr);
      return set | (cur & ~clr);
   endfunction

   // Undervoltage comes from the supplying regulator monitor
   assign raw_async = {tx_i, rx_bus_i, fault_i.over_temp, fault_i.rx_clamp,
                       fault_i.bus_short,
                       (uv_sel_reg3_i ? reg3_uv_i : reg2_uv_i)};
   // Transmit and receive idle recessive high
   assign sync_reset_val = {TX_RECESSIVE, TX_RECESSIVE, 4'h0};

   sync_bits #(
      .WIDTH (NSYNC)
   ) u_sync (
      .core_clk_i  (core_clk_i),
      .rst_b_i     (rst_b_i),
      .async_i     (raw_async),
      .reset_val_i (sync_reset_val),
      .sync_o      (raw_sync)
   );

   assign {tx_s, rx_s, ot_s, clamp_s, short_s, uv_s} = raw_sync;

   assign tx_mode = (mode_i == CAN_MODE_NORMAL);
   assign tx_rise = (tx_prev_r == TX_DOMINANT) && (tx_s == TX_RECESSIVE);

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         tx_prev_r <= TX_RECESSIVE;
      end else begin
         tx_prev_r <= tx_s;
      end
   end

   // Overtemperature lock: held while hot, then released on the first
   // recessive edge so a half-sent bit never reaches the bus.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         ot_lock_r <= 1'b0;
      end else if (ot_s) begin
         ot_lock_r <= 1'b1;
      end else if (ot_lock_r && tx_rise) begin
         ot_lock_r <= 1'b0;
      end
   end

   // Clamp lock only a host command releases; a pending fault wins
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         clamp_lock_r <= 1'b0;
      end else if (clamp_s) begin
         clamp_lock_r <= 1'b1;
      end else if (tx_reenable_i) begin
         clamp_lock_r <= 1'b0;
      end
   end

   // A live sensor blocks at once, before its lock register has caught up
   assign ot_block    = ot_s || ot_lock_r;
   assign clamp_block = clamp_s || clamp_lock_r;

   // Mode comes only from the host; bus shorts do not touch it
   assign tx_enable_nxt = tx_mode && !ot_block && !clamp_block;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         drv_enable_o <= 1'b0;
      end else begin
         drv_enable_o <= tx_enable_nxt;
      end
   end

   // Data is forced recessive with the enable, so a blocked driver never
   // shows a stale dominant bit to the output stage
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         drv_tx_o <= TX_RECESSIVE;
      end else begin
         drv_tx_o <= tx_enable_nxt ? tx_s : TX_RECESSIVE;
      end
   end

   // Receive path passes the bus level in normal and receive-only modes; host echo compare relies on it
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rx_o <= TX_RECESSIVE;
      end else begin
         rx_o <= rx_path_on(mode_i) ? rx_s : TX_RECESSIVE;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         split_enable_o <= 1'b0;
      end else begin
         split_enable_o <= rx_path_on(mode_i);
      end
   end

   // Overtemperature flag
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         ot_flag_r <= DIAG_RESET.over_temp;
      end else begin
         ot_flag_r <= keep_flag(ot_s, ot_flag_r, diag_clear_i.over_temp);
      end
   end

   // Receive clamp flag
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         clamp_flag_r <= DIAG_RESET.rx_clamp;
      end else begin
         clamp_flag_r <= keep_flag(clamp_s, clamp_flag_r, diag_clear_i.rx_clamp);
      end
   end

   // Bus short flag
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         short_flag_r <= DIAG_RESET.bus_short;
      end else begin
         short_flag_r <= keep_flag(short_s, short_flag_r, diag_clear_i.bus_short);
      end
   end

   // Supply undervoltage is only reported; switching off is left to the host
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         uv_flag_r <= DIAG_RESET.supply_uv;
      end else begin
         uv_flag_r <= keep_flag(uv_s, uv_flag_r, diag_clear_i.supply_uv);
      end
   end

   // Flags are plain flip-flops gathered into the record
   assign diag_o = '{over_temp: ot_flag_r,
                     rx_clamp:  clamp_flag_r,
                     bus_short: short_flag_r,
                     supply_uv: uv_flag_r};

   // Interrupt tracks the next flag value so it rises together with the flag
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         irq_bus_o <= 1'b0;
      end else begin
         irq_bus_o <= keep_flag(short_s, short_flag_r, diag_clear_i.bus_short)
                      & ~bus_short_mask_i;
      end
   end

endmodule
`default_nettype wire

// ### verilog/sync_bits.sv
// Two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module sync_bits
   import can_fault_pkg::*;
#(
   parameter int WIDTH = 5
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] async_i,
   input  wire logic [WIDTH-1:0] reset_val_i,
   output var  logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         // Stored inverted against the idle level, so both stages rest at idle
         meta_r <= '0;
         sync_o <= reset_val_i;
      end else begin
         meta_r <= async_i ^ reset_val_i;
         sync_o <= meta_r ^ reset_val_i;
      end
   end

endmodule
`default_nettype wire
